// File: rtl/orf_filter_top.sv
// Off-core response event filter register bank and qualification
`timescale 1ns/1ps
`default_nettype none
module orf_filter_top
  import orf_pkg::*;
#(
  parameter orf_variant_t VARIANT = ORF_VAR_CLIENT,
  parameter int NUM_EVT = 2,
  parameter int EVT_SEL_W = 1
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic [7:0] regAddr,
  input wire logic [31:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [31:0] regRdata,
  input wire logic [EVT_SEL_W-1:0] evtSel,
  input wire orf_resp_t resp,
  output logic countPulse
);
  // ==========================================================
  // Register address decode
  // Bank layout: each event owns a 16-byte window (lo, hi, count)
  localparam int WIN_SHIFT = 4;

  function automatic logic [EVT_SEL_W-1:0] winIdx(input logic [7:0] a);
    winIdx = EVT_SEL_W'(a >> WIN_SHIFT);
  endfunction

  function automatic logic [7:0] winOff(input logic [7:0] a);
    winOff = a & 8'h0f;
  endfunction

  wire logic [EVT_SEL_W-1:0] accIdx;
  wire logic [7:0] accOff;
  wire logic idxOk;
  wire logic hitLo;
  wire logic hitHi;
  wire logic hitCnt;

  assign accIdx = winIdx(regAddr);
  assign accOff = winOff(regAddr);
  assign idxOk = (32'(regAddr >> WIN_SHIFT) < NUM_EVT);
  assign hitLo = idxOk && (accOff == ORF_OFF_FILTER_LO);
  assign hitHi = idxOk && (accOff == ORF_OFF_FILTER_HI);
  assign hitCnt = idxOk && (accOff == ORF_OFF_MATCH_CNT);

  // ==========================================================
  // Filter storage, one register per event code
  logic [ORF_REG_W-1:0] filter_ff [NUM_EVT];
  logic [31:0] matchCnt_ff [NUM_EVT];
  logic [31:0] regRdata_ff;
  logic countPulse_ff;

  wire logic [ORF_REG_W-1:0] curFilter;
  wire logic [ORF_REG_W-1:0] rawWrite;
  wire logic [ORF_REG_W-1:0] cleanWrite;
  wire logic [ORF_REG_W-1:0] selFilter;
  wire logic evtHit;

  assign curFilter = filter_ff[accIdx];
  // Low word write keeps the upper bits; high word write keeps the lower 32
  assign rawWrite = hitLo ? {curFilter[ORF_REG_W-1:32], regWdata} :
                    {regWdata[ORF_REG_W-33:0], curFilter[31:0]};

  // Reserved bits are forced to zero so a careless write cannot widen a match
  orf_field_mask #(
    .VARIANT(VARIANT)
  ) uMask (
    .rawValue(rawWrite),
    .cleanValue(cleanWrite)
  );

  always_ff @(posedge clk_sys) begin
    for (int i = 0; i < NUM_EVT; i++) begin
      if (sys_rst) begin
        filter_ff[i] <= ORF_FILTER_RST;
      end else if (regWr && (hitLo || hitHi) && (accIdx == EVT_SEL_W'(i))) begin
        filter_ff[i] <= cleanWrite;
      end
    end
  end

  // ==========================================================
  // Qualification of responses against the selected event's filter
  assign selFilter = filter_ff[evtSel];

  orf_match uMatch (
    .filterValue(selFilter),
    .resp(resp),
    .hit(evtHit)
  );

  // Per-event match count shows the block's own state to software
  always_ff @(posedge clk_sys) begin
    for (int i = 0; i < NUM_EVT; i++) begin
      if (sys_rst) begin
        matchCnt_ff[i] <= ORF_CNT_RST;
      end else if (regWr && hitCnt && (accIdx == EVT_SEL_W'(i))) begin
        matchCnt_ff[i] <= regWdata;
      end else if (evtHit && (evtSel == EVT_SEL_W'(i))) begin
        matchCnt_ff[i] <= matchCnt_ff[i] + 32'h0000_0001;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      countPulse_ff <= 1'b0;
    end else begin
      countPulse_ff <= evtHit;
    end
  end

  // ==========================================================
  // Read data, valid only the cycle after the read strobe
  wire logic [31:0] nxt_regRdata;

  assign nxt_regRdata = !regRd ? 32'h0000_0000 :
                        hitLo ? curFilter[31:0] :
                        hitHi ? {{(64 - ORF_REG_W){1'b0}}, curFilter[ORF_REG_W-1:32]} :
                        hitCnt ? matchCnt_ff[accIdx] :
                        32'h0000_0000;

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      regRdata_ff <= 32'h0000_0000;
    end else begin
      regRdata_ff <= nxt_regRdata;
    end
  end

  assign regRdata = regRdata_ff;
  assign countPulse = countPulse_ff;
endmodule
`default_nettype wire

// File: inc/orf_pkg.sv
// Package for the off-core response event filter: layout, variants, register map
package orf_pkg;
  // ==========================================================
  // Filter register layout
  localparam int ORF_REG_W = 38;
  localparam int ORF_REQ_LSB = 0;
  localparam int ORF_REQ_MSB = 15;
  localparam int ORF_SUP_LSB = 16;
  localparam int ORF_SUP_MSB = 30;
  localparam int ORF_SNP_LSB = 31;
  localparam int ORF_SNP_MSB = 37;
  localparam int ORF_REQ_W = ORF_REQ_MSB - ORF_REQ_LSB + 1;
  localparam int ORF_SUP_W = ORF_SUP_MSB - ORF_SUP_LSB + 1;
  localparam int ORF_SNP_W = ORF_SNP_MSB - ORF_SNP_LSB + 1;

  // ==========================================================
  // Request type bit positions within the request field
  localparam int ORF_REQ_DMND_DATA = 0;
  localparam int ORF_REQ_DMND_OWN = 1;
  localparam int ORF_REQ_DMND_CODE = 2;
  localparam int ORF_REQ_L2PF_DATA = 4;
  localparam int ORF_REQ_L2PF_OWN = 5;
  localparam int ORF_REQ_L2PF_CODE = 6;
  localparam int ORF_REQ_OTHER = 15;
  localparam logic [15:0] ORF_REQ_IMPL_MASK = 16'h8077;

  // ==========================================================
  // Supplier bit positions, absolute within the filter register
  localparam int ORF_SUP_ANY = 16;
  localparam int ORF_SUP_NOINFO = 17;
  localparam int ORF_SUP_LLC_M = 18;
  localparam int ORF_SUP_LLC_E = 19;
  localparam int ORF_SUP_LLC_S = 20;
  localparam int ORF_SUP_LLC_F = 21;
  localparam int ORF_SUP_LOCAL = 22;
  localparam int ORF_SUP_L4_LOCAL = 22;
  localparam int ORF_SUP_L4_HOP0 = 23;
  localparam int ORF_SUP_L4_HOP1 = 24;
  localparam int ORF_SUP_L4_HOP2P = 25;
  localparam int ORF_SUP_RMT_HOP0 = 27;
  localparam int ORF_SUP_RMT_HOP1 = 28;
  localparam int ORF_SUP_RMT_HOP2P = 29;

  // Writable supplier bits per variant (bits 30:16 of the register)
  localparam logic [14:0] ORF_SUP_MASK_CLIENT = 15'h005f;
  localparam logic [14:0] ORF_SUP_MASK_L4 = 15'h03df;
  localparam logic [14:0] ORF_SUP_MASK_SERVER = 15'h387f;

  // ==========================================================
  // Register map and reset values
  localparam logic [7:0] ORF_OFF_FILTER_LO = 8'h00;
  localparam logic [7:0] ORF_OFF_FILTER_HI = 8'h04;
  localparam logic [7:0] ORF_OFF_MATCH_CNT = 8'h08;
  localparam logic [ORF_REG_W-1:0] ORF_FILTER_RST = 38'h00_0000_0000;
  localparam logic [31:0] ORF_CNT_RST = 32'h0000_0000;

  typedef enum logic [1:0] {
    ORF_VAR_CLIENT,
    ORF_VAR_L4,
    ORF_VAR_SERVER
  } orf_variant_t;

  // One off-core response from the core-uncore interface
  typedef struct packed {
    logic valid;
    logic [ORF_REQ_W-1:0] reqType;
    logic [ORF_SUP_W-1:0] supplier;
    logic [ORF_SNP_W-1:0] snoop;
  } orf_resp_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } orf_bus_req_t;
endpackage

// File: rtl/orf_field_mask.sv
// Reserved-bit masking of a filter write per product variant
`timescale 1ns/1ps
`default_nettype none
module orf_field_mask
  import orf_pkg::*;
#(
  parameter orf_variant_t VARIANT = ORF_VAR_CLIENT
) (
  input wire logic [ORF_REG_W-1:0] rawValue,
  output logic [ORF_REG_W-1:0] cleanValue
);
  // ==========================================================
  // Variant select
  wire logic [ORF_SUP_W-1:0] supKeep;

  assign supKeep = (VARIANT == ORF_VAR_SERVER) ? ORF_SUP_MASK_SERVER :
                   (VARIANT == ORF_VAR_L4) ? ORF_SUP_MASK_L4 :
                   ORF_SUP_MASK_CLIENT;

  // Reserved positions never hold a one, whatever software writes
  assign cleanValue = {rawValue[ORF_SNP_MSB:ORF_SNP_LSB],
                       rawValue[ORF_SUP_MSB:ORF_SUP_LSB] & supKeep,
                       rawValue[ORF_REQ_MSB:ORF_REQ_LSB] & ORF_REQ_IMPL_MASK};
endmodule
`default_nettype wire

// File: rtl/orf_match.sv
// Match of one response against the filter fields
`timescale 1ns/1ps
`default_nettype none
module orf_match
  import orf_pkg::*;
(
  input wire logic [ORF_REG_W-1:0] filterValue,
  input wire orf_resp_t resp,
  output logic hit
);
  // ==========================================================
  // Field compare
  wire logic reqHit;
  wire logic supHit;
  wire logic snpHit;
  wire logic [ORF_SUP_W-1:0] supSel;

  assign supSel = filterValue[ORF_SUP_MSB:ORF_SUP_LSB];
  assign reqHit = |(filterValue[ORF_REQ_MSB:ORF_REQ_LSB] & resp.reqType);
  // Catch-all bypasses every other supplier bit
  assign supHit = supSel[ORF_SUP_ANY - ORF_SUP_LSB] | (|(supSel & resp.supplier));
  assign snpHit = |(filterValue[ORF_SNP_MSB:ORF_SNP_LSB] & resp.snoop);
  assign hit = resp.valid & reqHit & supHit & snpHit;
endmodule
`default_nettype wire

// File: bench/orf_filter_monitor.sv
// Port checker for the off-core response filter
`timescale 1ns/1ps
`default_nettype none
module orf_filter_monitor
  import orf_pkg::*;
#(
  parameter orf_variant_t VARIANT = ORF_VAR_CLIENT,
  parameter int NUM_EVT = 2,
  parameter int EVT_SEL_W = 1
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic [7:0] regAddr,
  input wire logic [31:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  input wire logic [31:0] regRdata,
  input wire logic [EVT_SEL_W-1:0] evtSel,
  input wire orf_resp_t resp,
  input wire logic countPulse
);
  // ==========================================================
  // Supplier bits kept by this variant
  localparam logic [14:0] SUP_MASK = (VARIANT == ORF_VAR_SERVER) ? ORF_SUP_MASK_SERVER :
    (VARIANT == ORF_VAR_L4) ? ORF_SUP_MASK_L4 : ORF_SUP_MASK_CLIENT;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  rd_idle_zero_a: assert property (!$past(regRd) |-> regRdata == 32'h0)
    else $error("read data not zero when idle");
  unmapped_rd_a: assert property ($past(regRd) && ($past(regAddr[7:4]) >= NUM_EVT ||
    !($past(regAddr[3:0]) inside {4'h0, 4'h4, 4'h8})) |-> regRdata == 32'h0)
    else $error("unmapped read not zero");
  hi_word_width_a: assert property ($past(regRd) && $past(regAddr[3:0]) == 4'h4
    |-> regRdata[31:6] == 26'h0)
    else $error("high word beyond snoop field");
  req_rsvd_zero_a: assert property ($past(regRd) && $past(regAddr[3:0]) == 4'h0
    |-> (regRdata[15:0] & ~ORF_REQ_IMPL_MASK) == 16'h0)
    else $error("reserved request bit read back");
  sup_rsvd_zero_a: assert property ($past(regRd) && $past(regAddr[3:0]) == 4'h0
    |-> (regRdata[30:16] & ~SUP_MASK) == 15'h0)
    else $error("reserved supplier bit read back");
  pulse_cause_a: assert property (countPulse |-> $past(resp.valid))
    else $error("count without response");
  rsvd_req_miss_a: assert property (resp.valid && (resp.reqType & ORF_REQ_IMPL_MASK) == 16'h0
    |=> !countPulse)
    else $error("count on reserved request type");
  no_snoop_miss_a: assert property (resp.valid && resp.snoop == 7'h0 |=> !countPulse)
    else $error("count without snoop match");
endmodule
bind orf_filter_top orf_filter_monitor #(.VARIANT(VARIANT), .NUM_EVT(NUM_EVT),
  .EVT_SEL_W(EVT_SEL_W)) u_orf_filter_monitor (.clk_sys(clk_sys), .sys_rst(sys_rst),
  .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
  .regRdata(regRdata), .evtSel(evtSel), .resp(resp), .countPulse(countPulse));
`default_nettype wire

// File: bench/orf_filter_top_tb_top.sv
// Register and match testbench for the off-core response filter
`timescale 1ns/1ps
`default_nettype none
module orf_filter_top_tb_top
  import orf_pkg::*;
;
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic [7:0] regAddr = 8'h00;
  logic [31:0] regWdata = 32'h0;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  logic [31:0] regRdata;
  logic [0:0] evtSel = 1'b0;
  orf_resp_t resp = '0;
  logic countPulse;
  logic [31:0] regRdataSrv;
  logic [31:0] regRdataL4;
  int failCount = 0;
  int checksDone = 0;
  int hits [2] = '{0, 0};
  int reqBits [7] = '{0, 1, 2, 4, 5, 6, 15};
  int supBits [5] = '{1, 2, 3, 4, 6};
  always #4 clk_sys = ~clk_sys;
  orf_filter_top u_orf_filter_top (.clk_sys(clk_sys), .sys_rst(sys_rst), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
    .evtSel(evtSel), .resp(resp), .countPulse(countPulse));
  // Other variants see the same bus, so one write sequence checks every supplier mask
  orf_filter_top #(.VARIANT(ORF_VAR_SERVER)) u_orf_filter_top_srv (.clk_sys(clk_sys),
    .sys_rst(sys_rst), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
    .regRd(regRd), .regRdata(regRdataSrv), .evtSel(evtSel), .resp(resp), .countPulse());
  orf_filter_top #(.VARIANT(ORF_VAR_L4)) u_orf_filter_top_l4 (.clk_sys(clk_sys),
    .sys_rst(sys_rst), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
    .regRd(regRd), .regRdata(regRdataL4), .evtSel(evtSel), .resp(resp), .countPulse());
  // ==========================================================
  // Access tasks
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checksDone++;
    if (seen !== exp) begin
      failCount++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    regWr <= 1'b1;
    regAddr <= a;
    regWdata <= d;
    @(posedge clk_sys);
    regWr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk_sys);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge clk_sys);
    regRd <= 1'b0;
    #1 check(regRdata, exp);
  endtask
  // Pulse stands one cycle only, so it is sampled right after the taking edge
  task automatic sendResp(input logic [0:0] e, input logic [15:0] q, input logic [14:0] s,
      input logic [6:0] n, input logic exp);
    @(posedge clk_sys);
    resp <= {1'b1, q, s, n};
    evtSel <= e;
    @(posedge clk_sys);
    resp.valid <= 1'b0;
    #1 check({31'h0, countPulse}, {31'h0, exp});
    if (exp) hits[e]++;
  endtask
  task automatic testDone;
    $display("checks %0d mismatches %0d", checksDone, failCount);
    if (failCount == 0 && checksDone > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge clk_sys);
    failCount++;
    testDone();
  end
  // ==========================================================
  // Test sequence
  initial begin
    repeat (2) @(posedge clk_sys);
    sys_rst <= 1'b0;
    rd(8'h00, 32'h0);
    rd(8'h14, 32'h0);
    rd(8'h08, 32'h0);
    $display("reset test done");
    wr(8'h00, 32'hffff_ffff);
    wr(8'h04, 32'hffff_ffff);
    rd(8'h00, {1'b1, ORF_SUP_MASK_CLIENT, ORF_REQ_IMPL_MASK});
    check(regRdataSrv, {1'b1, ORF_SUP_MASK_SERVER, ORF_REQ_IMPL_MASK});
    check(regRdataL4, {1'b1, ORF_SUP_MASK_L4, ORF_REQ_IMPL_MASK});
    rd(8'h04, 32'h0000_003f);
    wr(8'h0c, 32'hffff_ffff);
    rd(8'h0c, 32'h0);
    rd(8'h20, 32'h0);
    sendResp(1'b1, 16'h0001, 15'h0001, 7'h01, 1'b0);
    $display("layout test done");
    foreach (reqBits[i]) begin
      wr(8'h00, {1'b1, 15'h0004, 16'(1 << reqBits[i])});
      sendResp(1'b0, 16'(1 << reqBits[i]), 15'h0004, 7'h01, 1'b1);
      sendResp(1'b0, ~16'(1 << reqBits[i]), 15'h0004, 7'h01, 1'b0);
    end
    foreach (supBits[i]) begin
      wr(8'h00, {1'b1, 15'(1 << supBits[i]), 16'h0001});
      sendResp(1'b0, 16'h0001, 15'(1 << supBits[i]), 7'h01, 1'b1);
      sendResp(1'b0, 16'h0001, 15'h7ffe & ~15'(1 << supBits[i]), 7'h01, 1'b0);
    end
    wr(8'h00, 32'h8001_0001);
    sendResp(1'b0, 16'h0001, 15'h0000, 7'h01, 1'b1);
    sendResp(1'b0, 16'h0001, 15'h0000, 7'h00, 1'b0);
    wr(8'h00, 32'h8020_0001);
    rd(8'h00, 32'h8000_0001);
    sendResp(1'b0, 16'h0001, 15'h0020, 7'h01, 1'b0);
    wr(8'h10, 32'h8001_0001);
    sendResp(1'b1, 16'h0001, 15'h0000, 7'h01, 1'b1);
    rd(8'h08, 32'(hits[0]));
    rd(8'h18, 32'(hits[1]));
    $display("match test done");
    testDone();
  end
endmodule
`default_nettype wire
